//--- verilog/atsp_cfg.svh
// constants of the async timer: register map, fields, reset values, timing
// assumes a 40 MHz system clock and an 8-bit register map on AXI4-Lite
`ifndef ATSP_CFG_SVH
`define ATSP_CFG_SVH
`define ATSP_OFS_COUNT   8'h00
`define ATSP_OFS_CMPA    8'h04
`define ATSP_OFS_CMPB    8'h08
`define ATSP_OFS_CTLA    8'h0C
`define ATSP_OFS_CTLB    8'h10
`define ATSP_OFS_ASTAT   8'h14
`define ATSP_OFS_GCTL    8'h18
`define ATSP_OFS_IMASK   8'h1C
`define ATSP_OFS_IFLAG   8'h20
`define ATSP_RST_REG     8'h00
`define ATSP_NUM_ASYNC   5
`define ATSP_IDX_COUNT   3'd0
`define ATSP_IDX_CMPA    3'd1
`define ATSP_IDX_CMPB    3'd2
`define ATSP_IDX_CTLB    3'd4
`define ATSP_BIT_AS      5
`define ATSP_BIT_PSR     0
`define ATSP_BIT_CMPA    0
`define ATSP_BIT_CMPB    1
`define ATSP_BIT_OVF     2
`define ATSP_CS_LSB      0
`define ATSP_XFER_EDGES  2'd2
`define ATSP_HALT_CYC    3'd4
`define ATSP_FLAG_SYNC   3
`define ATSP_RESP_OKAY   2'b00
`define ATSP_RESP_SLVERR 2'b10
`endif

//--- verilog/atsp_pkg.sv
// types of the async timer: bus carriers, clock selects, wake states
// assumes atsp_cfg.svh for all numbers
package atsp_pkg;
	typedef struct packed {
		logic       awvalid;
		logic [7:0] awaddr;
		logic       wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic       bready;
		logic       arvalid;
		logic [7:0] araddr;
		logic       rready;
	} atsp_axi_req_t;
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} atsp_axi_rsp_t;
	typedef enum logic [2:0] {
		ATSP_CS_STOP, ATSP_CS_DIV1, ATSP_CS_DIV8, ATSP_CS_DIV32,
		ATSP_CS_DIV64, ATSP_CS_DIV128, ATSP_CS_DIV256, ATSP_CS_DIV1024
	} atsp_clk_sel_t;
	typedef enum logic [1:0] {
		ATSP_RUN  = 2'b00,
		ATSP_WAIT = 2'b01,
		ATSP_HALT = 2'b11
	} atsp_wake_t;
endpackage

//--- verilog/atsp_timer.sv
// async-capable 8-bit timer core: holding registers, busy flags, prescaler,
// read-back copy, flag latency and sleep wake sequencing, AXI4-Lite slave.
// assumes the oscillator pin is far slower than i_sys_clk (over 4x).
//
// Overview of operation
// - async writes land after two oscillator edges
// - five registers, each with own holding register
// - busy flag per register until transfer
// - pending count or compare write blocks matching
// - clock switch leaves timer registers undefined
// - wake begins on next timer clock
// - processor halted four cycles after wake
// - count read through copy refreshed per edge
// - flag visible three cycles after timer tick when async, with the tick when synchronous
// - compare pin changes on timer clock
// - clock select bit picks oscillator pin
// - oscillator pins detached while async selected
// - stop, undivided, 8..1024 prescaler taps
// - prescaler reset bit clears prescaler
// - oscillator runs while async selected, except power-down and standby
// - registers lost after deep sleep wake
// - re-sleep in same cycle wakes again
`timescale 1ns/1ps
`include "atsp_cfg.svh"
module atsp_timer (
	input  wire logic                   i_sys_clk,
	input  wire logic                   i_rstn,
	input  wire atsp_pkg::atsp_axi_req_t i_axi,
	output atsp_pkg::atsp_axi_rsp_t     o_axi,
	input  wire logic                   i_osc_in_pin,
	input  wire logic                   i_sleep_save,
	input  wire logic                   i_sleep_deep,
	output logic                        o_osc_pins_detached,
	output logic                        o_osc_enable,
	output logic                        o_cmp_out,
	output logic                        o_timer_irq,
	output logic                        o_wake,
	output logic                        o_cpu_halt
);
	localparam int N = `ATSP_NUM_ASYNC;

	// oscillator pin synchroniser, edge taken from the second stage on
	logic       osc_s1_q, osc_s2_q, osc_s3_q;
	logic       osc_rise;
	always_ff @(posedge i_sys_clk) begin
		osc_s1_q <= i_osc_in_pin;
		osc_s2_q <= osc_s1_q;
		osc_s3_q <= osc_s2_q;
	end
	assign osc_rise = osc_s2_q & ~osc_s3_q;

	function automatic logic [7:0] lo8(input logic [31:0] v);
		return v[7:0];
	endfunction

	// register state
	logic [7:0] hold_q [N], hold_d [N];
	logic [7:0] dest_q [N], dest_d [N];
	logic [1:0] edg_q  [N], edg_d  [N];
	logic [N-1:0] busy_q, busy_d;
	logic       as_q, as_d;
	logic [7:0] imask_q, imask_d;
	logic [2:0] iflag_q, iflag_d;
	logic [9:0] pre_q, pre_d;
	logic [7:0] rdcnt_q, rdcnt_d;
	logic [2:0] fpipe_q [`ATSP_FLAG_SYNC], fpipe_d [`ATSP_FLAG_SYNC];
	logic       cmp_q, cmp_d;
	logic       deep_q, deep_d;

	// bus state
	logic       awh_q, awh_d, wh_q, wh_d, bv_q, bv_d, rv_q, rv_d;
	logic [7:0] awa_q, awa_d;
	logic [31:0] wdat_q, wdat_d, rdat_q, rdat_d;
	logic [1:0] bres_q, bres_d, rres_q, rres_d;
	logic [3:0] wstb_q, wstb_d;

	logic       src_tick, tick, do_wr, tmr_hit, psr_wr;
	logic [2:0] tev;
	logic [2:0] wsel;
	logic       wmap;
	atsp_pkg::atsp_clk_sel_t cs;

	assign cs = atsp_pkg::atsp_clk_sel_t'(dest_q[`ATSP_IDX_CTLB][`ATSP_CS_LSB +: 3]);
	assign src_tick = as_q ? osc_rise : 1'b1;
	assign do_wr = awh_q & wh_q & ~bv_q;

	// prescaler taps; divide by n ticks when the low bits of the prescaler are all ones
	always_comb begin
		unique case (cs)
			atsp_pkg::ATSP_CS_STOP:    tick = 1'b0;
			atsp_pkg::ATSP_CS_DIV1:    tick = src_tick;
			atsp_pkg::ATSP_CS_DIV8:    tick = src_tick & (&pre_q[2:0]);
			atsp_pkg::ATSP_CS_DIV32:   tick = src_tick & (&pre_q[4:0]);
			atsp_pkg::ATSP_CS_DIV64:   tick = src_tick & (&pre_q[5:0]);
			atsp_pkg::ATSP_CS_DIV128:  tick = src_tick & (&pre_q[6:0]);
			atsp_pkg::ATSP_CS_DIV256:  tick = src_tick & (&pre_q[7:0]);
			atsp_pkg::ATSP_CS_DIV1024: tick = src_tick & (&pre_q[9:0]);
		endcase
	end

	// bus write decode
	always_comb begin
		wmap = 1'b1;
		wsel = 3'd0;
		unique case (awa_q)
			`ATSP_OFS_COUNT: wsel = 3'd0;
			`ATSP_OFS_CMPA:  wsel = 3'd1;
			`ATSP_OFS_CMPB:  wsel = 3'd2;
			`ATSP_OFS_CTLA:  wsel = 3'd3;
			`ATSP_OFS_CTLB:  wsel = 3'd4;
			`ATSP_OFS_ASTAT, `ATSP_OFS_GCTL,
			`ATSP_OFS_IMASK, `ATSP_OFS_IFLAG: wsel = 3'd5;
			default: wmap = 1'b0;
		endcase
	end
	assign psr_wr = do_wr & wstb_q[0] & (awa_q == `ATSP_OFS_GCTL) & wdat_q[`ATSP_BIT_PSR];

	// timer datapath
	always_comb begin
		hold_d = hold_q;
		dest_d = dest_q;
		edg_d  = edg_q;
		busy_d = busy_q;
		as_d   = as_q;
		imask_d = imask_q;
		pre_d  = src_tick ? pre_q + 10'h001 : pre_q;
		cmp_d  = cmp_q;
		deep_d = i_sleep_deep;
		tev    = 3'b000;
		tmr_hit = 1'b0;
		if (psr_wr)
			pre_d = 10'h000;
		// pending transfers count oscillator edges, or land at once when synchronous
		for (int i = 0; i < N; i++) begin
			if (busy_q[i]) begin
				if (!as_q) begin
					dest_d[i] = hold_q[i];
					busy_d[i] = 1'b0;
				end else if (osc_rise) begin
					if (edg_q[i] == `ATSP_XFER_EDGES - 2'd1) begin
						dest_d[i] = hold_q[i];
						busy_d[i] = 1'b0;
					end
					edg_d[i] = edg_q[i] + 2'd1;
				end
			end
		end
		// counter advance; a landing count value overrides the increment
		if (tick && !(busy_q[`ATSP_IDX_COUNT] && busy_d[`ATSP_IDX_COUNT] == 1'b0)) begin
			dest_d[`ATSP_IDX_COUNT] = dest_q[`ATSP_IDX_COUNT] + 8'h01;
			tev[`ATSP_BIT_OVF] = (dest_q[`ATSP_IDX_COUNT] == 8'hFF);
		end
		// matching is blocked while count or compare writes are pending
		if (tick && !busy_q[`ATSP_IDX_COUNT] && !busy_q[`ATSP_IDX_CMPA] && !busy_q[`ATSP_IDX_CMPB]) begin
			tev[`ATSP_BIT_CMPA] = (dest_q[`ATSP_IDX_COUNT] == dest_q[`ATSP_IDX_CMPA]);
			tev[`ATSP_BIT_CMPB] = (dest_q[`ATSP_IDX_COUNT] == dest_q[`ATSP_IDX_CMPB]);
		end
		tmr_hit = |tev;
		if (tev[`ATSP_BIT_CMPA])
			cmp_d = ~cmp_q;
		// each register owns its holding slot, so writes never disturb each other
		if (do_wr && wstb_q[0] && wmap) begin
			if (wsel < 3'd5) begin
				hold_d[wsel] = lo8(wdat_q);
				busy_d[wsel] = 1'b1;
				edg_d[wsel]  = 2'd0;
			end else if (awa_q == `ATSP_OFS_ASTAT) begin
				// no retiming of live registers on a switch; contents are undefined
				as_d = wdat_q[`ATSP_BIT_AS];
			end else if (awa_q == `ATSP_OFS_IMASK) begin
				imask_d = lo8(wdat_q);
			end
		end
		// a wake from deep sleep clears all five registers, their holding copies and busy flags
		if (deep_q && !i_sleep_deep) begin
			for (int i = 0; i < N; i++) begin
				dest_d[i] = `ATSP_RST_REG;
				hold_d[i] = `ATSP_RST_REG;
			end
			busy_d = '0;
		end
	end

	// flag transport: three system cycles after the timer tick when async
	always_comb begin
		fpipe_d[0] = as_q ? tev : 3'b000;
		for (int s = 1; s < `ATSP_FLAG_SYNC; s++)
			fpipe_d[s] = fpipe_q[s-1];
		iflag_d = iflag_q;
		if (do_wr && wstb_q[0] && awa_q == `ATSP_OFS_IFLAG)
			iflag_d = iflag_q & ~wdat_q[2:0];
		// set wins over a clear in the same cycle
		iflag_d = iflag_d | (as_q ? fpipe_q[`ATSP_FLAG_SYNC-1] : tev);
	end

	// read copy follows the counter one cycle after each oscillator edge while awake
	always_comb begin
		rdcnt_d = rdcnt_q;
		if (!as_q)
			rdcnt_d = dest_q[`ATSP_IDX_COUNT];
		else if (osc_s3_q && !osc_s2_q ? 1'b0 : osc_rise && !i_sleep_save)
			rdcnt_d = dest_d[`ATSP_IDX_COUNT];
	end

	// wake sequencing
	atsp_pkg::atsp_wake_t wst_q, wst_d;
	logic [2:0] hcnt_q, hcnt_d;
	logic       irq_cond;
	assign irq_cond = |(iflag_q & imask_q[2:0]);
	always_comb begin
		wst_d  = wst_q;
		hcnt_d = hcnt_q;
		unique case (wst_q)
			atsp_pkg::ATSP_RUN:
				// a flag still pending on re-entry wakes again on the next timer clock
				if (i_sleep_save && irq_cond)
					wst_d = atsp_pkg::ATSP_WAIT;
			atsp_pkg::ATSP_WAIT:
				if (src_tick) begin
					wst_d  = atsp_pkg::ATSP_HALT;
					hcnt_d = `ATSP_HALT_CYC;
				end
			atsp_pkg::ATSP_HALT: begin
				hcnt_d = hcnt_q - 3'd1;
				if (hcnt_q == 3'd1)
					wst_d = atsp_pkg::ATSP_RUN;
			end
			default: wst_d = atsp_pkg::ATSP_RUN;
		endcase
	end

	// bus handshake and read mux
	always_comb begin
		awh_d = awh_q;
		awa_d = awa_q;
		wh_d  = wh_q;
		wdat_d = wdat_q;
		wstb_d = wstb_q;
		bv_d  = bv_q;
		bres_d = bres_q;
		rv_d  = rv_q;
		rdat_d = rdat_q;
		rres_d = rres_q;
		if (i_axi.awvalid && !awh_q) begin
			awh_d = 1'b1;
			awa_d = i_axi.awaddr;
		end
		if (i_axi.wvalid && !wh_q) begin
			wh_d   = 1'b1;
			wdat_d = i_axi.wdata;
			wstb_d = i_axi.wstrb;
		end
		if (do_wr) begin
			awh_d  = 1'b0;
			wh_d   = 1'b0;
			bv_d   = 1'b1;
			bres_d = wmap ? `ATSP_RESP_OKAY : `ATSP_RESP_SLVERR;
		end
		if (bv_q && i_axi.bready)
			bv_d = 1'b0;
		if (rv_q && i_axi.rready)
			rv_d = 1'b0;
		if (i_axi.arvalid && !rv_q) begin
			rv_d   = 1'b1;
			rres_d = `ATSP_RESP_OKAY;
			rdat_d = 32'h0000_0000;
			unique case (i_axi.araddr)
				`ATSP_OFS_COUNT: rdat_d[7:0] = rdcnt_q;
				`ATSP_OFS_CMPA:  rdat_d[7:0] = dest_q[1];
				`ATSP_OFS_CMPB:  rdat_d[7:0] = dest_q[2];
				`ATSP_OFS_CTLA:  rdat_d[7:0] = dest_q[3];
				`ATSP_OFS_CTLB:  rdat_d[7:0] = dest_q[4];
				`ATSP_OFS_ASTAT: rdat_d[7:0] = {2'b00, as_q, busy_q};
				`ATSP_OFS_GCTL:  rdat_d[7:0] = 8'h00;
				`ATSP_OFS_IMASK: rdat_d[7:0] = imask_q;
				`ATSP_OFS_IFLAG: rdat_d[7:0] = {5'b00000, iflag_q};
				default:         rres_d = `ATSP_RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			for (int i = 0; i < N; i++) begin
				hold_q[i] <= `ATSP_RST_REG;
				dest_q[i] <= `ATSP_RST_REG;
				edg_q[i]  <= 2'd0;
			end
			for (int s = 0; s < `ATSP_FLAG_SYNC; s++)
				fpipe_q[s] <= 3'b000;
			busy_q  <= '0;
			as_q    <= 1'b0;
			imask_q <= `ATSP_RST_REG;
			iflag_q <= 3'b000;
			pre_q   <= 10'h000;
			rdcnt_q <= `ATSP_RST_REG;
			cmp_q   <= 1'b0;
			deep_q  <= 1'b0;
			wst_q   <= atsp_pkg::ATSP_RUN;
			hcnt_q  <= 3'd0;
			awh_q   <= 1'b0;
			awa_q   <= 8'h00;
			wh_q    <= 1'b0;
			wdat_q  <= 32'h0000_0000;
			wstb_q  <= 4'h0;
			bv_q    <= 1'b0;
			bres_q  <= `ATSP_RESP_OKAY;
			rv_q    <= 1'b0;
			rdat_q  <= 32'h0000_0000;
			rres_q  <= `ATSP_RESP_OKAY;
		end else begin
			hold_q  <= hold_d;
			dest_q  <= dest_d;
			edg_q   <= edg_d;
			fpipe_q <= fpipe_d;
			busy_q  <= busy_d;
			as_q    <= as_d;
			imask_q <= imask_d;
			iflag_q <= iflag_d;
			pre_q   <= pre_d;
			rdcnt_q <= rdcnt_d;
			cmp_q   <= cmp_d;
			deep_q  <= deep_d;
			wst_q   <= wst_d;
			hcnt_q  <= hcnt_d;
			awh_q   <= awh_d;
			awa_q   <= awa_d;
			wh_q    <= wh_d;
			wdat_q  <= wdat_d;
			wstb_q  <= wstb_d;
			bv_q    <= bv_d;
			bres_q  <= bres_d;
			rv_q    <= rv_d;
			rdat_q  <= rdat_d;
			rres_q  <= rres_d;
		end
	end

	assign o_axi.awready = ~awh_q;
	assign o_axi.wready  = ~wh_q;
	assign o_axi.bvalid  = bv_q;
	assign o_axi.bresp   = bres_q;
	assign o_axi.arready = ~rv_q;
	assign o_axi.rvalid  = rv_q;
	assign o_axi.rdata   = rdat_q;
	assign o_axi.rresp   = rres_q;
	assign o_osc_pins_detached = as_q;
	assign o_osc_enable = as_q & ~i_sleep_deep;
	assign o_cmp_out   = cmp_q;
	assign o_timer_irq = irq_cond;
	assign o_wake      = (wst_q == atsp_pkg::ATSP_HALT);
	assign o_cpu_halt  = (wst_q == atsp_pkg::ATSP_HALT);
endmodule

//--- tb/atsp_timer_asserts.sv
// port checker of the async timer
// assumes binding onto atsp_timer, one clock domain
`timescale 1ns/1ps
module atsp_timer_asserts (
	input wire logic                    i_sys_clk,
	input wire logic                    i_rstn,
	input wire atsp_pkg::atsp_axi_req_t i_axi,
	input wire atsp_pkg::atsp_axi_rsp_t o_axi,
	input wire logic                    i_sleep_deep,
	input wire logic                    o_osc_pins_detached,
	input wire logic                    o_osc_enable,
	input wire logic                    o_timer_irq,
	input wire logic                    o_wake,
	input wire logic                    o_cpu_halt
);
	default clocking @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rstn);
	a_osc_deep_off: assert property (i_sleep_deep |-> !o_osc_enable)
		else $error("osc on in deep sleep");
	a_osc_keep_on: assert property (!i_sleep_deep && o_osc_pins_detached |-> o_osc_enable)
		else $error("osc stopped");
	a_pins_detach: assert property (o_osc_enable |-> o_osc_pins_detached)
		else $error("pins not detached");
	a_halt_four: assert property ($rose(o_cpu_halt) |-> o_cpu_halt [*4] ##1 !o_cpu_halt)
		else $error("halt length");
	a_wake_halt: assert property (o_wake == o_cpu_halt)
		else $error("wake and halt differ");
	a_wake_irq: assert property ($rose(o_wake) |-> o_timer_irq)
		else $error("wake without irq");
	a_read_lat: assert property (i_axi.arvalid && o_axi.arready |=> o_axi.rvalid)
		else $error("read late");
	a_write_resp: assert property (i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready
		|-> ##[1:2] o_axi.bvalid)
		else $error("write response late");
	a_read_drop: assert property (o_axi.rvalid && i_axi.rready |=> !o_axi.rvalid)
		else $error("rvalid stuck");
endmodule
bind atsp_timer atsp_timer_asserts atsp_timer_asserts_i (
	.i_sys_clk           (i_sys_clk),
	.i_rstn              (i_rstn),
	.i_axi               (i_axi),
	.o_axi               (o_axi),
	.i_sleep_deep        (i_sleep_deep),
	.o_osc_pins_detached (o_osc_pins_detached),
	.o_osc_enable        (o_osc_enable),
	.o_timer_irq         (o_timer_irq),
	.o_wake              (o_wake),
	.o_cpu_halt          (o_cpu_halt)
);

//--- tb/atsp_osc_model.sv
// crystal on the oscillator pins
// assumes i_en low whenever the device stops the oscillator
`timescale 1ns/1ps
module atsp_osc_model #(parameter int HALF_NS = 200) (
	input  wire logic i_en,
	input  wire logic i_slow,
	output logic      o_pin
);
	// even the fast period spans 16 system clocks
	initial begin
		o_pin = 1'b0;
		forever begin
			#(i_slow ? 3 * HALF_NS : HALF_NS);
			// a stopped crystal rests low
			o_pin = i_en ? ~o_pin : 1'b0;
		end
	end
endmodule

//--- tb/async_timer_sync_prescaler_tb_top.sv
// self-checking bench of the async timer
// assumes the bound checker and the crystal model
`timescale 1ns/1ps
`include "atsp_cfg.svh"
module async_timer_sync_prescaler_tb_top;
	logic                    i_sys_clk;
	logic                    i_rstn;
	atsp_pkg::atsp_axi_req_t req;
	atsp_pkg::atsp_axi_rsp_t rsp;
	logic                    osc, sv, dp, slow, det, oen, cmp, irq, wake, halt, cmp0;
	logic [34:0]             exp_q[$];
	logic [34:0]             e;
	logic [7:0]              rdat;
	int                      n_fail, samples_checked, seed, i, t0;
	int                      dv[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
	atsp_timer atsp_timer_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_axi(req), .o_axi(rsp),
		.i_osc_in_pin(osc), .i_sleep_save(sv), .i_sleep_deep(dp), .o_osc_pins_detached(det),
		.o_osc_enable(oen), .o_cmp_out(cmp), .o_timer_irq(irq), .o_wake(wake), .o_cpu_halt(halt));
	atsp_osc_model atsp_osc_model_i (.i_en(oen), .i_slow(slow), .o_pin(osc));
	initial begin
		i_sys_clk = 1'b0;
		forever #12.5 i_sys_clk = ~i_sys_clk;
	end
	task automatic chk(input logic [33:0] s, input logic [33:0] x);
		samples_checked++;
		if (s !== x) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen %h want %h", $time, s, x);
		end
	endtask
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = `ATSP_RESP_OKAY);
		@(posedge i_sys_clk);
		exp_q.push_back({1'b1, er, 32'h0});
		req.awvalid <= 1'b1;
		req.awaddr  <= a;
		req.wvalid  <= 1'b1;
		req.wdata   <= {24'h0, d};
		req.bready  <= 1'b1;
		do begin
			@(posedge i_sys_clk);
			if (rsp.awready)
				req.awvalid <= 1'b0;
			if (rsp.wready)
				req.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		req.bready <= 1'b0;
	endtask
	// c low: polling read, the watcher skips its compare
	task automatic rd(input logic [7:0] a, input logic [7:0] x, input bit c = 1,
		input logic [1:0] er = `ATSP_RESP_OKAY);
		@(posedge i_sys_clk);
		exp_q.push_back({c, er, 24'h0, x});
		req.arvalid <= 1'b1;
		req.araddr  <= a;
		req.rready  <= 1'b1;
		do begin
			@(posedge i_sys_clk);
			if (rsp.arready)
				req.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		rdat = rsp.rdata[7:0];
		req.rready <= 1'b0;
	endtask
	task automatic wait_idle(input logic [7:0] m);
		do rd(`ATSP_OFS_ASTAT, 8'h00, 0); while ((rdat & m) !== 8'h00);
	endtask
	always @(posedge i_sys_clk) begin
		if ((rsp.rvalid && req.rready) || (rsp.bvalid && req.bready)) begin
			e = exp_q.pop_front();
			if (e[34])
				chk(req.rready ? {rsp.rresp, rsp.rdata} : {rsp.bresp, 32'h0}, e[33:0]);
		end
	end
	initial begin
		req = '0;
		req.wstrb = 4'hF;
		{sv, dp, slow, i_rstn} = 4'h0;
		{n_fail, samples_checked, seed} = {32'd0, 32'd0, 32'd68306};
		repeat (5) @(posedge i_sys_clk);
		i_rstn <= 1'b1;
		rd(`ATSP_OFS_ASTAT, 8'h00);
		rd(8'h24, 8'h00, 1, `ATSP_RESP_SLVERR);
		wr(8'h24, 8'h12, `ATSP_RESP_SLVERR);
		t0 = $random(seed);
		wr(`ATSP_OFS_COUNT, t0[7:0]);
		rd(`ATSP_OFS_COUNT, t0[7:0]);
		for (i = 0; i < 8; i++) begin
			wr(`ATSP_OFS_CTLB, 8'h00);
			wr(`ATSP_OFS_COUNT, 8'h00);
			wr(`ATSP_OFS_GCTL, 8'h01);
			wr(`ATSP_OFS_CTLB, 8'(i));
			repeat (dv[i] == 0 ? 64 : 8 * dv[i]) @(posedge i_sys_clk);
			wr(`ATSP_OFS_CTLB, 8'h00);
			rd(`ATSP_OFS_COUNT, 8'h00, 0);
			chk(34'(dv[i] == 0 ? rdat == 0 : rdat >= 7 && rdat <= 9 + 8 / dv[i]), 34'h1);
		end
		rd(`ATSP_OFS_GCTL, 8'h00);
		wr(`ATSP_OFS_ASTAT, 8'h20);
		#1 chk({32'h0, det, oen}, 34'h3);
		wait_idle(8'h1F);
		slow <= 1'b1;
		t0 = int'($time);
		wr(`ATSP_OFS_CMPA, 8'h03);
		rd(`ATSP_OFS_ASTAT, 8'h22);
		wr(`ATSP_OFS_CMPB, 8'h66);
		rd(`ATSP_OFS_ASTAT, 8'h26);
		wait_idle(8'h06);
		chk(34'($time - t0 >= 400), 34'h1);
		rd(`ATSP_OFS_CMPA, 8'h03);
		rd(`ATSP_OFS_CMPB, 8'h66);
		slow <= 1'b0;
		wr(`ATSP_OFS_COUNT, 8'h00);
		wr(`ATSP_OFS_CTLB, 8'h01);
		wait_idle(8'h1F);
		// flags left over from the synchronous runs must go before the mask opens
		wr(`ATSP_OFS_IFLAG, 8'h07);
		wr(`ATSP_OFS_IMASK, 8'h01);
		cmp0 = cmp;
		sv <= 1'b1;
		for (i = 0; i < 4000 && wake !== 1'b1; i++) @(posedge i_sys_clk);
		chk({31'h0, wake, irq, cmp}, {31'h0, 2'b11, ~cmp0});
		sv <= 1'b0;
		rd(`ATSP_OFS_IFLAG, 8'h01);
		wr(`ATSP_OFS_IFLAG, 8'h01);
		#1 chk({33'h0, irq}, 34'h0);
		dp <= 1'b1;
		repeat (4) @(posedge i_sys_clk);
		dp <= 1'b0;
		// oscillator settling wait, far shorter than a real crystal needs
		repeat (8) @(posedge i_sys_clk);
		rd(`ATSP_OFS_CMPA, 8'h00);
		wr(`ATSP_OFS_ASTAT, 8'h00);
		#1 chk({32'h0, det, oen}, 34'h0);
		end_of_test();
	end
	// whole run is under 0.6 ms of simulated time; limit stays below 100k clocks
	initial begin
		#2000000;
		n_fail++;
		end_of_test();
	end
endmodule
